// File: rtl/cff_flag_bank.sv
// Fault status register and clear-on-read event flag registers of the charge controller.
//
// Contract
// - Bit 7 shows input under-voltage protection.
// - Bit 6 shows input over-voltage protection.
// - Bit 5 shows battery over-current detected.
// - Bit 4 shows battery over-voltage protection.
// - Bit 3 shows thermal shutdown protection.
// - Bit 2 shows charge safety timer expired.
// - Bit 1 shows gate-drive supply out of range.
// - Battery-only, converter off: supply bit reads one.
// - Fault status at 0x24 resets to zero.
// - One-shot conversion done sets sticky flag A7.
// - Conversion flag reads zero in continuous mode.
// - Entering input current regulation sets A6.
// - Entering input voltage regulation sets A5.
// - Watchdog expiry rising edge sets A3.
// - Constant-voltage timer rising edge sets A1.
// - Any charge-state change sets A0.
// - Power-good toggle sets B7.
// - Any thermistor state change sets B4.
// - Reverse-mode toggle sets B3.
// - Sync-clock status change sets B1.
// - Any power-tracking state change sets B0.
// - Unmasked flag events pulse the interrupt.
`timescale 1ns/10ps

module cff_flag_bank (
    input  wire logic                 CLK,               // System clock, 100 MHz.
    input  wire logic                 RST_B,             // Synchronous reset, active low.
    input  wire cff_pkg::cff_status_t STATUS,            // Live protection and charger status.
    input  wire logic                 ADC_ONE_SHOT,      // Converter in one-shot mode when high.
    input  wire logic                 ADC_ENABLED,       // Converter enabled when high.
    input  wire logic                 ADC_DONE,          // One-cycle conversion-complete pulse.
    input  wire logic                 BATTERY_ONLY,      // Device running from the battery only.
    input  wire cff_pkg::cff_read_req_t RD_REQ,          // Register read strobe and address.
    input  wire cff_pkg::cff_masks_t  MASKS,             // Interrupt masks, one suppresses.
    output logic [7:0]                RD_DATA,           // Read data, valid with RD_VALID.
    output logic                      RD_VALID,          // One-cycle read answer strobe.
    output logic                      INT_PULSE          // One-cycle interrupt pulse.
);

    // ****************************************************************
    // Address decode
    // ****************************************************************
    function automatic logic addr_hit(input cff_pkg::cff_read_req_t req, input logic [7:0] offset);
        addr_hit = req.strobe & (req.addr == offset);
    endfunction

    logic rd_fault_status;
    logic rd_event_a;
    logic rd_event_b;
    logic rd_fault_flags;

    assign rd_fault_status = addr_hit(RD_REQ, cff_pkg::CFF_ADDR_FAULT_STATUS);
    assign rd_event_a      = addr_hit(RD_REQ, cff_pkg::CFF_ADDR_EVENT_A);
    assign rd_event_b      = addr_hit(RD_REQ, cff_pkg::CFF_ADDR_EVENT_B);
    assign rd_fault_flags  = addr_hit(RD_REQ, cff_pkg::CFF_ADDR_FAULT_FLAGS);

    // ****************************************************************
    // Fault status register
    // ****************************************************************
    logic [7:0] fault_live;
    logic [7:0] protection_fault_status_reg;

    always_comb begin
        fault_live                              = cff_pkg::CFF_RESET_VALUE;
        fault_live[cff_pkg::CFF_FS_INPUT_UV]     = STATUS.input_undervoltage_status;
        fault_live[cff_pkg::CFF_FS_INPUT_OV]     = STATUS.input_overvoltage_status;
        fault_live[cff_pkg::CFF_FS_BATTERY_OC]   = STATUS.battery_overcurrent_status;
        fault_live[cff_pkg::CFF_FS_BATTERY_OV]   = STATUS.battery_overvoltage_status;
        fault_live[cff_pkg::CFF_FS_THERMAL_SHDN] = STATUS.thermal_shutdown_status;
        fault_live[cff_pkg::CFF_FS_SAFETY_TIMER] = STATUS.safety_timer_expired_status;
        fault_live[cff_pkg::CFF_FS_GATE_SUPPLY]  = STATUS.gate_drive_supply_fault_status
                                                 | (BATTERY_ONLY & ~ADC_ENABLED);
    end

    // The status register trails the live conditions by one cycle; the
    // reserved low bit stays zero.
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            protection_fault_status_reg <= cff_pkg::CFF_RESET_VALUE;
        end else begin
            protection_fault_status_reg <= fault_live;
        end
    end

    // ****************************************************************
    // Event flag register A
    // ****************************************************************
    logic [7:0] flags_a;
    logic [7:0] events_a;
    logic       conv_done_flag;

    assign flags_a[4] = 1'b0;
    assign flags_a[2] = 1'b0;
    assign events_a[4] = 1'b0;
    assign events_a[2] = 1'b0;

    cff_event_cell #(.W(1), .RISE_ONLY(1'b1)) u_conv_done (
        .clk         (CLK),
        .rst_b       (RST_B),
        .level       (ADC_DONE),
        .qualify     (ADC_ONE_SHOT),
        .clear       (rd_event_a),
        .flag        (conv_done_flag),
        .event_pulse (events_a[cff_pkg::CFF_EA_CONV_DONE])
    );

    // A flag caught in one-shot mode is hidden once continuous mode runs.
    assign flags_a[cff_pkg::CFF_EA_CONV_DONE] = conv_done_flag & ADC_ONE_SHOT;

    cff_event_cell #(.W(1), .RISE_ONLY(1'b1)) u_input_curr (
        .clk         (CLK),
        .rst_b       (RST_B),
        .level       (STATUS.input_current_regulation),
        .qualify     (1'b1),
        .clear       (rd_event_a),
        .flag        (flags_a[cff_pkg::CFF_EA_INPUT_CURR]),
        .event_pulse (events_a[cff_pkg::CFF_EA_INPUT_CURR])
    );

    cff_event_cell #(.W(1), .RISE_ONLY(1'b1)) u_input_volt (
        .clk         (CLK),
        .rst_b       (RST_B),
        .level       (STATUS.input_voltage_regulation),
        .qualify     (1'b1),
        .clear       (rd_event_a),
        .flag        (flags_a[cff_pkg::CFF_EA_INPUT_VOLT]),
        .event_pulse (events_a[cff_pkg::CFF_EA_INPUT_VOLT])
    );

    cff_event_cell #(.W(1), .RISE_ONLY(1'b1)) u_watchdog (
        .clk         (CLK),
        .rst_b       (RST_B),
        .level       (STATUS.watchdog_expiry_status),
        .qualify     (1'b1),
        .clear       (rd_event_a),
        .flag        (flags_a[cff_pkg::CFF_EA_WATCHDOG]),
        .event_pulse (events_a[cff_pkg::CFF_EA_WATCHDOG])
    );

    cff_event_cell #(.W(1), .RISE_ONLY(1'b1)) u_cv_timer (
        .clk         (CLK),
        .rst_b       (RST_B),
        .level       (STATUS.cv_timer_expired),
        .qualify     (1'b1),
        .clear       (rd_event_a),
        .flag        (flags_a[cff_pkg::CFF_EA_CV_TIMER]),
        .event_pulse (events_a[cff_pkg::CFF_EA_CV_TIMER])
    );

    cff_event_cell #(.W(3), .RISE_ONLY(1'b0)) u_charge_state (
        .clk         (CLK),
        .rst_b       (RST_B),
        .level       (STATUS.charge_state),
        .qualify     (1'b1),
        .clear       (rd_event_a),
        .flag        (flags_a[cff_pkg::CFF_EA_CHARGE_STATE]),
        .event_pulse (events_a[cff_pkg::CFF_EA_CHARGE_STATE])
    );

    // ****************************************************************
    // Event flag register B
    // ****************************************************************
    logic [7:0] flags_b;
    logic [7:0] events_b;

    assign flags_b[6]  = 1'b0;
    assign flags_b[5]  = 1'b0;
    assign flags_b[2]  = 1'b0;
    assign events_b[6] = 1'b0;
    assign events_b[5] = 1'b0;
    assign events_b[2] = 1'b0;

    cff_event_cell #(.W(1), .RISE_ONLY(1'b0)) u_power_good (
        .clk         (CLK),
        .rst_b       (RST_B),
        .level       (STATUS.input_power_good),
        .qualify     (1'b1),
        .clear       (rd_event_b),
        .flag        (flags_b[cff_pkg::CFF_EB_POWER_GOOD]),
        .event_pulse (events_b[cff_pkg::CFF_EB_POWER_GOOD])
    );

    cff_event_cell #(.W(3), .RISE_ONLY(1'b0)) u_thermistor (
        .clk         (CLK),
        .rst_b       (RST_B),
        .level       (STATUS.thermistor_state),
        .qualify     (1'b1),
        .clear       (rd_event_b),
        .flag        (flags_b[cff_pkg::CFF_EB_THERMISTOR]),
        .event_pulse (events_b[cff_pkg::CFF_EB_THERMISTOR])
    );

    cff_event_cell #(.W(1), .RISE_ONLY(1'b0)) u_reverse (
        .clk         (CLK),
        .rst_b       (RST_B),
        .level       (STATUS.reverse_mode),
        .qualify     (1'b1),
        .clear       (rd_event_b),
        .flag        (flags_b[cff_pkg::CFF_EB_REVERSE]),
        .event_pulse (events_b[cff_pkg::CFF_EB_REVERSE])
    );

    cff_event_cell #(.W(2), .RISE_ONLY(1'b0)) u_sync_clock (
        .clk         (CLK),
        .rst_b       (RST_B),
        .level       (STATUS.switching_sync_clock_pin),
        .qualify     (1'b1),
        .clear       (rd_event_b),
        .flag        (flags_b[cff_pkg::CFF_EB_SYNC_CLOCK]),
        .event_pulse (events_b[cff_pkg::CFF_EB_SYNC_CLOCK])
    );

    cff_event_cell #(.W(2), .RISE_ONLY(1'b0)) u_power_track (
        .clk         (CLK),
        .rst_b       (RST_B),
        .level       (STATUS.power_tracking_state),
        .qualify     (1'b1),
        .clear       (rd_event_b),
        .flag        (flags_b[cff_pkg::CFF_EB_POWER_TRACK]),
        .event_pulse (events_b[cff_pkg::CFF_EB_POWER_TRACK])
    );

    // ****************************************************************
    // Fault flag register, one rising-edge flag per fault status bit
    // ****************************************************************
    logic [7:0] flags_f;
    logic [7:0] events_f;

    assign flags_f[0]  = 1'b0;
    assign events_f[0] = 1'b0;

    generate
        for (genvar i = cff_pkg::CFF_FS_LOW; i <= cff_pkg::CFF_FS_HIGH; i++) begin : g_fault
            cff_event_cell #(.W(1), .RISE_ONLY(1'b1)) u_fault (
                .clk         (CLK),
                .rst_b       (RST_B),
                .level       (fault_live[i]),
                .qualify     (1'b1),
                .clear       (rd_fault_flags),
                .flag        (flags_f[i]),
                .event_pulse (events_f[i])
            );
        end
    endgenerate

    // ****************************************************************
    // Read port
    // ****************************************************************
    logic [7:0] rd_data_next;

    // Unmapped addresses answer with zero.
    always_comb begin
        rd_data_next = cff_pkg::CFF_RESET_VALUE;
        if (rd_fault_status) begin
            rd_data_next = protection_fault_status_reg;
        end else if (rd_event_a) begin
            rd_data_next = flags_a;
        end else if (rd_event_b) begin
            rd_data_next = flags_b;
        end else if (rd_fault_flags) begin
            rd_data_next = flags_f;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            RD_DATA  <= cff_pkg::CFF_RESET_VALUE;
            RD_VALID <= 1'b0;
        end else begin
            RD_DATA  <= RD_REQ.strobe ? rd_data_next : cff_pkg::CFF_RESET_VALUE;
            RD_VALID <= RD_REQ.strobe;
        end
    end

    // ****************************************************************
    // Interrupt pulse
    // ****************************************************************
    logic int_next;

    assign int_next = |(events_a & ~MASKS.event_a)
                    | |(events_b & ~MASKS.event_b)
                    | |(events_f & ~MASKS.fault);

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            INT_PULSE <= 1'b0;
        end else begin
            INT_PULSE <= int_next;
        end
    end

endmodule

// File: rtl/cff_pkg.sv
// Package with register map, field positions and signal bundles of the charger fault and event flag bank.
package cff_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam int          CFF_ADDR_W            = 8;
    localparam int          CFF_DATA_W            = 8;
    localparam logic [7:0]  CFF_ADDR_FAULT_STATUS = 8'h24;
    localparam logic [7:0]  CFF_ADDR_EVENT_A      = 8'h25;
    localparam logic [7:0]  CFF_ADDR_EVENT_B      = 8'h26;
    localparam logic [7:0]  CFF_ADDR_FAULT_FLAGS  = 8'h27;
    localparam logic [7:0]  CFF_RESET_VALUE       = 8'h00;

    // ****************************************************************
    // Field positions of the fault status and fault flag registers
    // ****************************************************************
    localparam int CFF_FS_INPUT_UV     = 7;
    localparam int CFF_FS_INPUT_OV     = 6;
    localparam int CFF_FS_BATTERY_OC   = 5;
    localparam int CFF_FS_BATTERY_OV   = 4;
    localparam int CFF_FS_THERMAL_SHDN = 3;
    localparam int CFF_FS_SAFETY_TIMER = 2;
    localparam int CFF_FS_GATE_SUPPLY  = 1;
    localparam int CFF_FS_LOW          = 1;
    localparam int CFF_FS_HIGH         = 7;

    // ****************************************************************
    // Field positions of event flag register A
    // ****************************************************************
    localparam int CFF_EA_CONV_DONE    = 7;
    localparam int CFF_EA_INPUT_CURR   = 6;
    localparam int CFF_EA_INPUT_VOLT   = 5;
    localparam int CFF_EA_WATCHDOG     = 3;
    localparam int CFF_EA_CV_TIMER     = 1;
    localparam int CFF_EA_CHARGE_STATE = 0;

    // ****************************************************************
    // Field positions of event flag register B
    // ****************************************************************
    localparam int CFF_EB_POWER_GOOD   = 7;
    localparam int CFF_EB_THERMISTOR   = 4;
    localparam int CFF_EB_REVERSE      = 3;
    localparam int CFF_EB_SYNC_CLOCK   = 1;
    localparam int CFF_EB_POWER_TRACK  = 0;

    // ****************************************************************
    // Live status bundle from the charger core
    // ****************************************************************
    typedef struct packed {
        logic       input_undervoltage_status;
        logic       input_overvoltage_status;
        logic       battery_overcurrent_status;
        logic       battery_overvoltage_status;
        logic       thermal_shutdown_status;
        logic       safety_timer_expired_status;
        logic       gate_drive_supply_fault_status;
        logic       input_current_regulation;
        logic       input_voltage_regulation;
        logic       watchdog_expiry_status;
        logic       cv_timer_expired;
        logic [2:0] charge_state;
        logic       input_power_good;
        logic [2:0] thermistor_state;
        logic       reverse_mode;
        logic [1:0] switching_sync_clock_pin;
        logic [1:0] power_tracking_state;
    } cff_status_t;

    // ****************************************************************
    // Register read request and interrupt masks
    // ****************************************************************
    typedef struct packed {
        logic       strobe;
        logic [7:0] addr;
    } cff_read_req_t;

    typedef struct packed {
        logic [7:0] event_a;
        logic [7:0] event_b;
        logic [7:0] fault;
    } cff_masks_t;

endpackage

// File: rtl/cff_event_cell.sv
// Sticky clear-on-read event flag that sets on a change or a rising edge of a status field.
`timescale 1ns/10ps

module cff_event_cell #(
    parameter int W         = 1,
    parameter bit RISE_ONLY = 1'b0
) (
    input  wire logic         clk,         // System clock.
    input  wire logic         rst_b,       // Synchronous reset, active low.
    input  wire logic [W-1:0] level,       // Status field watched for changes.
    input  wire logic         qualify,     // Events count only while high.
    input  wire logic         clear,       // Register read that clears the flag.
    output logic              flag,        // Sticky flag.
    output logic              event_pulse  // One cycle on each detected event.
);

    logic         armed_reg;
    logic [W-1:0] prev_reg;
    logic         flag_reg;
    logic         change;

    // The first sample after reset only arms the detector, so a field that
    // is already non-zero at reset release does not count as a change.
    always_comb begin
        if (RISE_ONLY) begin
            change = level[0] & ~prev_reg[0];
        end else begin
            change = (level != prev_reg);
        end
    end

    assign event_pulse = armed_reg & qualify & change;
    assign flag        = flag_reg;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            armed_reg <= 1'b0;
            prev_reg  <= '0;
        end else begin
            armed_reg <= 1'b1;
            prev_reg  <= level;
        end
    end

    // A new event in the clearing cycle keeps the flag set.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            flag_reg <= 1'b0;
        end else begin
            flag_reg <= (flag_reg & ~clear) | event_pulse;
        end
    end

endmodule

// File: sim/cff_flag_bank_monitor.sv
// Checker of the read answers and interrupt pulses of the flag bank.
`timescale 1ns/10ps

module cff_flag_bank_monitor (
    input wire logic                   CLK,          // Clock.
    input wire logic                   RST_B,        // Reset, active low.
    input wire cff_pkg::cff_status_t   STATUS,       // Live status.
    input wire logic                   ADC_ONE_SHOT, // One-shot mode.
    input wire logic                   ADC_ENABLED,  // Converter on.
    input wire logic                   ADC_DONE,     // Conversion done.
    input wire logic                   BATTERY_ONLY, // Battery only.
    input wire cff_pkg::cff_read_req_t RD_REQ,       // Read request.
    input wire cff_pkg::cff_masks_t    MASKS,        // Interrupt masks.
    input wire logic [7:0]             RD_DATA,      // Read data.
    input wire logic                   RD_VALID,     // Read answer.
    input wire logic                   INT_PULSE     // Interrupt.
);
    default clocking @(posedge CLK);
    endclocking
    default disable iff (!RST_B);

    // ****************************************
    // Sequences
    // ****************************************
    sequence s_quiet;
        $stable(STATUS) && $stable(BATTERY_ONLY) && $stable(ADC_ENABLED) && $stable(ADC_DONE);
    endsequence

    sequence s_rd(a);
        RD_REQ.strobe && RD_REQ.addr == a;
    endsequence

    // ****************************************
    // Assertions
    // ****************************************
    AST_FAULT_LIVE: assert property (
        s_quiet [*3] ##0 s_rd(8'h24) |=> RD_VALID && RD_DATA[7:2] == $past({STATUS.input_undervoltage_status,
        STATUS.input_overvoltage_status, STATUS.battery_overcurrent_status, STATUS.battery_overvoltage_status,
        STATUS.thermal_shutdown_status, STATUS.safety_timer_expired_status}))
        else $error("fault status bits 7 to 2 wrong");
    AST_FAULT_SUPPLY: assert property (
        s_quiet [*3] ##0 s_rd(8'h24) |=>
        RD_DATA[1] == $past(STATUS.gate_drive_supply_fault_status || (BATTERY_ONLY && !ADC_ENABLED)))
        else $error("gate supply fault bit wrong");
    AST_FAULT_RSVD: assert property (s_rd(8'h24) |=> RD_DATA[0] == 1'b0)
        else $error("reserved fault bit set");
    AST_UNMAPPED: assert property (
        RD_REQ.strobe && (RD_REQ.addr < 8'h24 || RD_REQ.addr > 8'h27) |=> RD_VALID && RD_DATA == 8'h00)
        else $error("unmapped read not zero");
    AST_CLEAR_A: assert property (
        s_quiet [*3] ##0 s_rd(8'h25) ##1 (s_quiet and s_rd(8'h25)) |=> RD_DATA == 8'h00)
        else $error("flags A not cleared by read");
    AST_CLEAR_B: assert property (
        s_quiet [*3] ##0 s_rd(8'h26) ##1 (s_quiet and s_rd(8'h26)) |=> RD_DATA == 8'h00)
        else $error("flags B not cleared by read");
    AST_CONT_MODE: assert property (!ADC_ONE_SHOT [*2] ##0 s_rd(8'h25) |=> !RD_DATA[7])
        else $error("conversion flag seen in continuous mode");
    AST_INT_PG: assert property (
        $changed(STATUS.input_power_good) && !MASKS.event_b[7] |-> ##[1:2] INT_PULSE)
        else $error("unmasked power good toggle gave no interrupt");
    AST_INT_MASKED: assert property ((MASKS == 24'hFFFFFF) [*3] |-> !INT_PULSE)
        else $error("interrupt while all masked");
    AST_SET_WINS: assert property (
        s_rd(8'h26) ##0 $changed(STATUS.reverse_mode) ##1 s_rd(8'h26) |=> RD_DATA[3])
        else $error("event lost during clearing read");
endmodule

bind cff_flag_bank cff_flag_bank_monitor u_monitor (
    .CLK(CLK), .RST_B(RST_B), .STATUS(STATUS), .ADC_ONE_SHOT(ADC_ONE_SHOT), .ADC_ENABLED(ADC_ENABLED),
    .ADC_DONE(ADC_DONE), .BATTERY_ONLY(BATTERY_ONLY), .RD_REQ(RD_REQ), .MASKS(MASKS),
    .RD_DATA(RD_DATA), .RD_VALID(RD_VALID), .INT_PULSE(INT_PULSE)
);

// File: sim/cff_host_model.sv
// Host model that reads flag bank registers in back-to-back pairs.
`timescale 1ns/10ps

module cff_host_model (
    input  wire logic                   clk,      // System clock.
    output cff_pkg::cff_read_req_t      rd_req,   // Read request.
    input  wire logic [7:0]             rd_data,  // Read data.
    input  wire logic                   rd_valid  // Read answer.
);
    initial begin
        rd_req = '0;
    end

    // The second read shows what the first one left behind.
    task automatic read_pair(input logic [7:0] addr, output logic [7:0] d0, output logic [7:0] d1,
                             output logic ok);
        @(posedge clk);
        rd_req <= '{strobe: 1'b1, addr: addr};
        @(posedge clk);
        @(posedge clk);
        d0 = rd_data;
        ok = rd_valid;
        rd_req <= '0;
        @(posedge clk);
        d1 = rd_data;
        ok = ok & rd_valid;
    endtask
endmodule

// File: sim/testbench.sv
// Self-checking testbench of the charger fault and event flag bank.
`timescale 1ns/10ps

module testbench;
    logic                   clk;
    logic                   rst_b;
    cff_pkg::cff_status_t   status;
    cff_pkg::cff_status_t   st_o;
    logic                   one_shot;
    logic                   adc_en;
    logic                   adc_done;
    logic                   bat_only;
    logic                   bo_o;
    logic                   en_o;
    logic                   dn_o;
    cff_pkg::cff_read_req_t rd_req;
    cff_pkg::cff_masks_t    masks;
    logic [7:0]             rd_data;
    logic                   rd_valid;
    logic                   int_pulse;
    logic [7:0]             ea;
    logic [7:0]             eb;
    logic [7:0]             ef;
    logic [7:0]             d0;
    logic [7:0]             d1;
    logic                   ok;
    logic [31:0]            seed;
    logic [31:0]            m;
    int                     num_errors;
    int                     n_compared;

    cff_flag_bank dut (
        .CLK(clk), .RST_B(rst_b), .STATUS(status), .ADC_ONE_SHOT(one_shot), .ADC_ENABLED(adc_en),
        .ADC_DONE(adc_done), .BATTERY_ONLY(bat_only), .RD_REQ(rd_req), .MASKS(masks),
        .RD_DATA(rd_data), .RD_VALID(rd_valid), .INT_PULSE(int_pulse)
    );
    cff_host_model host (.clk(clk), .rd_req(rd_req), .rd_data(rd_data), .rd_valid(rd_valid));

    function automatic logic [31:0] xorshift(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic logic [7:0] fault_of(input cff_pkg::cff_status_t s, input logic bo, input logic en);
        return {s.input_undervoltage_status, s.input_overvoltage_status, s.battery_overcurrent_status,
                s.battery_overvoltage_status, s.thermal_shutdown_status, s.safety_timer_expired_status,
                s.gate_drive_supply_fault_status | (bo & ~en), 1'b0};
    endfunction

    function automatic logic [7:0] ev_a(input cff_pkg::cff_status_t o, input cff_pkg::cff_status_t n,
                                        input logic dn_old, input logic dn_new);
        return {dn_new & ~dn_old, n.input_current_regulation & ~o.input_current_regulation,
                n.input_voltage_regulation & ~o.input_voltage_regulation, 1'b0,
                n.watchdog_expiry_status & ~o.watchdog_expiry_status, 1'b0,
                n.cv_timer_expired & ~o.cv_timer_expired, n.charge_state != o.charge_state};
    endfunction

    function automatic logic [7:0] ev_b(input cff_pkg::cff_status_t o, input cff_pkg::cff_status_t n);
        return {n.input_power_good != o.input_power_good, 2'b00, n.thermistor_state != o.thermistor_state,
                n.reverse_mode != o.reverse_mode, 1'b0, n.switching_sync_clock_pin != o.switching_sync_clock_pin,
                n.power_tracking_state != o.power_tracking_state};
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        if (num_errors == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Applies new status at a rising edge and books the events it raises.
    task automatic step(input cff_pkg::cff_status_t s, input logic bo, input logic en, input logic dn);
        logic [23:0] ev;
        ev = {ev_a(st_o, s, dn_o, dn), ev_b(st_o, s), fault_of(s, bo, en) & ~fault_of(st_o, bo_o, en_o)};
        ea |= ev[23:16];
        eb |= ev[15:8];
        ef |= ev[7:0];
        status <= s;
        bat_only <= bo;
        adc_en <= en;
        adc_done <= dn;
        st_o = s;
        bo_o = bo;
        en_o = en;
        dn_o = dn;
        repeat (2) @(posedge clk);
        ev[23] = ev[23] & one_shot;
        check({7'h00, int_pulse}, {7'h00, |(ev & ~masks)});
        @(posedge clk);
    endtask

    task automatic rd_check(input logic [7:0] a, input logic [7:0] x0, input logic [7:0] x1);
        host.read_pair(a, d0, d1, ok);
        check({7'h00, ok}, 8'h01);
        check(d0, x0);
        check(d1, x1);
    endtask

    task automatic rd_reg(input logic [7:0] a);
        case (a)
            8'h24: rd_check(a, fault_of(st_o, bo_o, en_o), fault_of(st_o, bo_o, en_o));
            8'h25: rd_check(a, ea, 8'h00);
            8'h26: rd_check(a, eb, 8'h00);
            8'h27: rd_check(a, ef, 8'h00);
            default: rd_check(a, 8'h00, 8'h00);
        endcase
        if (a == 8'h25) ea = 8'h00;
        if (a == 8'h26) eb = 8'h00;
        if (a == 8'h27) ef = 8'h00;
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        #100000;
        num_errors++;
        close_out();
    end

    initial begin
        rst_b = 1'b0;
        status = '0;
        st_o = '0;
        one_shot = 1'b1;
        adc_en = 1'b0;
        adc_done = 1'b0;
        bat_only = 1'b0;
        {bo_o, en_o, dn_o} = 3'b000;
        masks = '0;
        {ea, eb, ef} = 24'h000000;
        seed = 32'd53;
        num_errors = 0;
        n_compared = 0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        for (int a = 8'h23; a <= 8'h28; a++) rd_reg(a[7:0]);
        // A conversion finishing in continuous mode leaves no visible flag.
        one_shot <= 1'b0;
        step(st_o, bo_o, en_o, 1'b1);
        ea[7] = 1'b0;
        rd_reg(8'h25);
        step(st_o, bo_o, en_o, 1'b0);
        one_shot <= 1'b1;
        step(st_o, 1'b1, 1'b0, 1'b0);
        rd_reg(8'h24);
        // Reverse-mode toggle lands on the edge of a clearing read.
        fork
            host.read_pair(8'h26, d0, d1, ok);
            begin
                @(posedge clk);
                status.reverse_mode <= ~st_o.reverse_mode;
            end
        join
        st_o.reverse_mode = ~st_o.reverse_mode;
        check(d0, eb);
        check(d1, 8'h08);
        for (int i = 0; i < 300; i++) begin
            seed = xorshift(seed);
            m = xorshift(seed);
            masks <= m[3] ? 24'hFFFFFF : m[31:8];
            step(seed[22:0], seed[25], seed[26], seed[27]);
            rd_reg(8'h24 + {5'h00, m[2:0]});
        end
        close_out();
    end
endmodule
